// ===== rtl/hcm_regs.vh
// register map constants for the hypervisor control block
`ifndef HCM_REGS_VH
`define HCM_REGS_VH
// ----------------------------------------
// offsets and reset values
// ----------------------------------------
`define HCM_HYPERVISOR_CONTROL_OFFSET 9'h000
`define HCM_HYPERVISOR_CONTROL_RESET  32'h00000000
`define HCM_ADDR_W                    9
// ----------------------------------------
// field positions
// ----------------------------------------
`define HCM_EN_BIT                    0
`define HCM_UNDERFLOW_BIT             1
`define HCM_MISSING_ENTRY_BIT         2
`define HCM_NO_PENDING_BIT            3
`define HCM_GRP0_EN_BIT               4
`define HCM_GRP0_DIS_BIT              5
`define HCM_GRP1_EN_BIT               6
`define HCM_GRP1_DIS_BIT              7
`define HCM_COUNT_LSB                 27
`define HCM_COUNT_MSB                 31
`define HCM_COUNT_W                   5
`define HCM_CTRL_MASK                 32'hF80000FF
`endif

// ===== rtl/hcm_eoi_counter.v
// unmatched end-of-interrupt counter with software load
`timescale 1ns/1ps
`include "hcm_regs.vh"
module hcm_eoi_counter (
  // clock and reset
  input  wire                    sys_clk,
  input  wire                    rst_n,
  // events
  input  wire                    count_event,
  // software load
  input  wire                    load,
  input  wire [`HCM_COUNT_W-1:0] load_value,
  // state
  output reg  [`HCM_COUNT_W-1:0] count
);
  // ----------------------------------------
  // counter
  // ----------------------------------------
  // an event in the write cycle still counts, on top of the written value
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 5'h00;
    end else if (load) begin
      count <= load_value + {4'h0, count_event};
    end else if (count_event) begin
      count <= count + 5'h01; // natural 5-bit wrap from 31 to 0 [RULE_04]
    end
  end
endmodule

// ===== rtl/hcm_top.v
// hypervisor control register and maintenance interrupt logic
//
// Summary of operation
// RULE_01: no virtual or maintenance interrupt while the interface enable is 0.
// RULE_02: five-bit counter in bits 31:27 counts EOIs with no list entry.
// RULE_03: EOIs that clear no active priority bit leave the counter alone.
// RULE_04: counter wraps from 31 to 0 instead of saturating.
// RULE_05: maintenance interrupt holds while count nonzero and missing-entry enable set.
// RULE_06: bit 7 set signals maintenance while VM group 1 enable is 0.
// RULE_07: bit 6 set signals maintenance while VM group 1 enable is 1.
// RULE_08: maintenance interrupt is a level following its conditions, not a pulse.
// RULE_09: missing-entry alert enable lives at bit 2.
// RULE_10: interface enable at bit 0; when clear acknowledge reads give spurious ID.
// RULE_11: maintenance output is OR of enabled conditions gated by interface enable.
`timescale 1ns/1ps
`include "hcm_regs.vh"
module hcm_top (
  // clock and reset
  input  wire                  sys_clk,
  input  wire                  reset_n,
  // register access
  input  wire                  reg_sel,
  input  wire                  reg_write,
  input  wire [`HCM_ADDR_W-1:0] reg_addr,
  input  wire [31:0]           reg_wdata,
  output reg  [31:0]           reg_rdata,
  // interface status inputs
  input  wire                  eoi_unmatched,
  input  wire                  eoi_apr_cleared,
  input  wire                  vm_group0_signal_enable,
  input  wire                  vm_group1_signal_enable,
  input  wire                  lr_none_pending,
  input  wire                  lr_underflow,
  input  wire                  virq_request,
  // outputs
  output reg                   maint_irq,
  output reg                   virq_out,
  output reg                   spurious_ack
);
  // ----------------------------------------
  // reset synchroniser
  // ----------------------------------------
  reg rst_meta;
  reg rst_n;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  function hit_ctrl;
    input [`HCM_ADDR_W-1:0] a;
    begin
      hit_ctrl = (a == `HCM_HYPERVISOR_CONTROL_OFFSET);
    end
  endfunction

  wire wr_ctrl = reg_sel & reg_write & hit_ctrl(reg_addr);
  wire rd_ctrl = reg_sel & ~reg_write & hit_ctrl(reg_addr);

  reg [7:0] ctrl_bits;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_bits <= 8'h00;
    end else if (wr_ctrl) begin
      ctrl_bits <= reg_wdata[7:0]; // enable at bit 0, missing-entry at bit 2 [RULE_09] [RULE_10]
    end
  end

  // ----------------------------------------
  // unmatched eoi counter
  // ----------------------------------------
  wire [`HCM_COUNT_W-1:0] unmatched_eoi_count;
  // only EOIs that also cleared an active priority bit may count
  wire count_event = eoi_unmatched & eoi_apr_cleared; // [RULE_02] [RULE_03]

  hcm_eoi_counter u_count (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .count_event(count_event),
    .load       (wr_ctrl),
    .load_value (reg_wdata[`HCM_COUNT_MSB:`HCM_COUNT_LSB]),
    .count      (unmatched_eoi_count)
  );

  wire hypervisor_en              = ctrl_bits[`HCM_EN_BIT];
  wire missing_entry_alert_enable = ctrl_bits[`HCM_MISSING_ENTRY_BIT];
  wire grp1_enabled_alert_enable  = ctrl_bits[`HCM_GRP1_EN_BIT];
  wire grp1_disabled_alert_enable = ctrl_bits[`HCM_GRP1_DIS_BIT];

  // ----------------------------------------
  // maintenance conditions
  // ----------------------------------------
  wire cond_missing = missing_entry_alert_enable &
                      (unmatched_eoi_count != 5'h00); // [RULE_05]
  wire cond_g1_dis  = grp1_disabled_alert_enable & ~vm_group1_signal_enable; // [RULE_06]
  wire cond_g1_en   = grp1_enabled_alert_enable & vm_group1_signal_enable; // [RULE_07]
  wire cond_g0_dis  = ctrl_bits[`HCM_GRP0_DIS_BIT] & ~vm_group0_signal_enable;
  wire cond_g0_en   = ctrl_bits[`HCM_GRP0_EN_BIT] & vm_group0_signal_enable;
  wire cond_np      = ctrl_bits[`HCM_NO_PENDING_BIT] & lr_none_pending;
  wire cond_uf      = ctrl_bits[`HCM_UNDERFLOW_BIT] & lr_underflow;

  wire next_maint_irq = hypervisor_en & (cond_missing | cond_g1_dis | cond_g1_en |
                        cond_g0_dis | cond_g0_en | cond_np | cond_uf); // [RULE_01] [RULE_11]

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // registered for clean timing; costs one cycle of latency on every output
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      maint_irq    <= 1'b0;
      virq_out     <= 1'b0;
      spurious_ack <= 1'b1;
      reg_rdata    <= 32'h00000000;
    end else begin
      maint_irq    <= next_maint_irq; // level, recomputed every cycle [RULE_08]
      virq_out     <= virq_request & hypervisor_en; // [RULE_01]
      spurious_ack <= ~hypervisor_en; // [RULE_10]
      if (rd_ctrl) begin
        reg_rdata <= {unmatched_eoi_count, 19'h00000, ctrl_bits} & `HCM_CTRL_MASK;
      end else if (reg_sel & ~reg_write) begin
        reg_rdata <= 32'h00000000;
      end
    end
  end
endmodule

// ===== tb/hcm_chk.sv
// port checker for the hypervisor control block
`timescale 1ns/1ps
module hcm_chk (
  input logic sys_clk, reset_n, reg_sel, reg_write, eoi_unmatched, eoi_apr_cleared,
  input logic vm_group0_signal_enable, vm_group1_signal_enable, lr_none_pending,
  input logic lr_underflow, virq_request, maint_irq, virq_out, spurious_ack,
  input logic [8:0] reg_addr,
  input logic [31:0] reg_wdata, reg_rdata);
  logic [31:0] sh;
  wire g1 = vm_group1_signal_enable;
  wire g0 = vm_group0_signal_enable;
  wire rd = reg_sel & !reg_write & reg_addr == 9'h000;
  wire wr = reg_sel & reg_write & reg_addr == 9'h000;
  wire ev = eoi_unmatched & eoi_apr_cleared;
  wire vq = virq_request & sh[0];
  wire cond = sh[0] & (sh[2] & |sh[31:27] | sh[7] & !g1 | sh[6] & g1 | sh[5] & !g0
    | sh[4] & g0 | sh[3] & lr_none_pending | sh[1] & lr_underflow);
  // shadow copy; a same-cycle event adds on top of a software load
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) sh <= 32'h0;
    else begin
      if (wr) sh <= reg_wdata & 32'hF80000FF;
      if (ev) sh[31:27] <= (wr ? reg_wdata[31:27] : sh[31:27]) + 5'h1;
    end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_en_gate: assert property (!$past(sh[0]) |-> !maint_irq && !virq_out)
    else $error("irq while disabled");
  chk_read_data: assert property (rd |=> reg_rdata == $past(sh))
    else $error("read mismatch");
  chk_missing_entry: assert property (sh[0] && sh[2] && sh[31:27] != 5'h0 |=> maint_irq)
    else $error("count irq missing");
  chk_grp1_dis: assert property (sh[0] && sh[7] && !g1 |=> maint_irq)
    else $error("grp1 disabled irq missing");
  chk_grp1_en: assert property (sh[0] && sh[6] && g1 |=> maint_irq)
    else $error("grp1 enabled irq missing");
  chk_level_hold: assert property (cond [*2] |=> maint_irq)
    else $error("irq not held");
  chk_maint_exact: assert property (maint_irq == $past(cond))
    else $error("irq not or of conditions");
  chk_spurious_ack: assert property (spurious_ack == !$past(sh[0]))
    else $error("spurious flag wrong");
  chk_virq_gate: assert property (virq_out == $past(vq))
    else $error("virq gate wrong");
  cover property (ev && sh[31:27] == 5'h1F);
  cover property ($rose(maint_irq));
  cover property (reg_sel && reg_addr != 9'h000);
endmodule

// ===== tb/test_hcm_top.sv
// self-checking bench for the hypervisor control block
`timescale 1ns/1ps
module test_hcm_top;
  logic sys_clk = 0, reset_n = 0, reg_sel = 0, reg_write = 0, eoi_unmatched = 0;
  logic eoi_apr_cleared = 0, vm_group0_signal_enable = 0, vm_group1_signal_enable = 0;
  logic lr_none_pending = 0, lr_underflow = 0, virq_request = 0;
  logic maint_irq, virq_out, spurious_ack;
  logic [8:0] reg_addr = 9'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  int errors = 0, cmp_count = 0;
  hcm_top u_hcm_top (.*);
  initial forever #50 sys_clk = ~sys_clk;
  task automatic check(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(logic w, logic [8:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_sel <= 1'b1;
    reg_write <= w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_sel <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [8:0] a, logic [31:0] e);
    acc(1'b0, a, 32'h0);
    check("reg_rdata", e, reg_rdata);
  endtask
  // outputs are registered, so allow two edges
  task automatic outs(logic m, logic v);
    repeat (2) @(posedge sys_clk);
    #1;
    check("maint_irq", {31'h0, m}, {31'h0, maint_irq});
    check("virq_out", {31'h0, v}, {31'h0, virq_out});
  endtask
  task automatic eoi(int n, logic apr);
    repeat (n) begin
      @(posedge sys_clk);
      eoi_unmatched <= 1'b1;
      eoi_apr_cleared <= apr;
    end
    @(posedge sys_clk);
    eoi_unmatched <= 1'b0;
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(9'h000, 32'h0);
    check("spurious_ack", 32'h1, {31'h0, spurious_ack});
    acc(1'b1, 9'h000, 32'hFFFFFFFF);
    rd(9'h000, 32'hF80000FF);
    acc(1'b1, 9'h0F0, 32'h1);
    rd(9'h0F0, 32'h0);
    $display("test registers done");
    acc(1'b1, 9'h000, 32'h5);
    eoi(1, 1'b0);
    rd(9'h000, 32'h5);
    outs(1'b0, 1'b0);
    eoi(31, 1'b1);
    rd(9'h000, 32'hF8000005);
    outs(1'b1, 1'b0);
    eoi(1, 1'b1);
    rd(9'h000, 32'h5);
    outs(1'b0, 1'b0);
    $display("test counter done");
    acc(1'b1, 9'h000, 32'h81);
    outs(1'b1, 1'b0);
    @(posedge sys_clk);
    vm_group1_signal_enable <= 1'b1;
    virq_request <= 1'b1;
    outs(1'b0, 1'b1);
    acc(1'b1, 9'h000, 32'h41);
    outs(1'b1, 1'b1);
    acc(1'b1, 9'h000, 32'hB);
    outs(1'b0, 1'b1);
    check("spurious_ack", 32'h0, {31'h0, spurious_ack});
    @(posedge sys_clk);
    lr_underflow <= 1'b1;
    outs(1'b1, 1'b1);
    @(posedge sys_clk);
    lr_underflow <= 1'b0;
    lr_none_pending <= 1'b1;
    outs(1'b1, 1'b1);
    acc(1'b1, 9'h000, 32'h31);
    outs(1'b1, 1'b1);
    acc(1'b1, 9'h000, 32'h40);
    outs(1'b0, 1'b0);
    check("spurious_ack", 32'h1, {31'h0, spurious_ack});
    $display("test groups done");
    end_sim();
  end
endmodule
bind hcm_top hcm_chk u_hcm_chk (.*);
